//--- common/rtirq_consts.svh
// register offsets, field positions and timing counts for the terminal register bank
`ifndef RTIRQ_CONSTS_SVH
`define RTIRQ_CONSTS_SVH
`define RTIRQ_IDX_HP_EN      5'h07
`define RTIRQ_IDX_HP_STAT    5'h08
`define RTIRQ_IDX_STD_EN     5'h09
`define RTIRQ_IDX_TADDR      5'h0A
`define RTIRQ_IDX_SELFTEST   5'h0B
`define RTIRQ_IDX_PRST       5'h0C
`define RTIRQ_IDX_TTRST      5'h0D
`define RTIRQ_IDX_MONCTL     5'h0E
`define RTIRQ_IDX_STW        5'h04
`define RTIRQ_IDX_IRQ_STAT   5'h10
`define RTIRQ_IDX_IRQ_CLR    5'h11
`define RTIRQ_IDX_IRQ_EN     5'h12
`define RTIRQ_IDX_TTAG       5'h13
`define RTIRQ_HP_MASK        16'h017B
`define RTIRQ_STD_MASK       16'h0032
`define RTIRQ_BIT_STD        0
`define RTIRQ_BIT_MSGERR     1
`define RTIRQ_BIT_STFAIL     3
`define RTIRQ_BIT_STDONE     4
`define RTIRQ_BIT_SSFAIL     5
`define RTIRQ_BIT_DBCA       6
`define RTIRQ_BIT_OVR        8
`define RTIRQ_BIT_ILLCMD     4
`define RTIRQ_BIT_ILLBC      5
`define RTIRQ_TA_ADDR_MASK   16'h003F
`define RTIRQ_TA_BUSYEN      9
`define RTIRQ_TA_BUSY        14
`define RTIRQ_MON_BIT        15
`define RTIRQ_CLK_MHZ        125
`define RTIRQ_SELFTEST_US    100
`define RTIRQ_PRST_US        1
`define RTIRQ_SELFTEST_CYC   (`RTIRQ_SELFTEST_US * `RTIRQ_CLK_MHZ)
`define RTIRQ_PRST_CYC       (`RTIRQ_PRST_US * `RTIRQ_CLK_MHZ)
`endif

//--- common/rtirq_pkg.sv
// types shared by the terminal register bank
package rtirq_pkg;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [6:0]  paddr;
    logic [31:0] pwdata;
  } rtirq_apb_req_type;

  typedef struct packed {
    logic msg_error;
    logic self_test_fail;
    logic dyn_bus_accept;
    logic data_overrun;
    logic illegal_cmd;
    logic illegal_bcast;
    logic cmd_done;
  } rtirq_events_type;

  typedef enum logic [1:0] {
    RTIRQ_IDLE,
    RTIRQ_SELFTEST,
    RTIRQ_PRESET
  } rtirq_state_type;
endpackage

//--- src/rtirq_regs.sv
// terminal interrupt, address/flags and command register bank with apb slave
// How it works
// (R1) high-priority output only for enabled events
// (R2) high-priority enable bit0 low: pulse only
// (R3) bit0 high: pulse and level both
// (R4) enabled message error halts until cleared
// (R5) event sets status bit, raises output
// (R6) writing one clears bit and output
// (R7) writing one to zero bit sets nothing
// (R8) subsystem fail pin sets status bit 5
// (R9) standard interrupts gated by standard enables
// (R10) address bits mirror pins while locked
// (R11) bits 10-15 drive status word flags
// (R12) busy bit applied when command processing idle
// (R13) self-test write runs 100 us, result word
// (R14) reset write stops terminal for 1 us
// (R15) time-tag write clears 8-bit counter
// (R16) monitor bit 15 reads current mode
// (R17) result word sent on self-test mode code
// (R18) command registers read zero, no effect
//
// Decided for this implementation: the placing of the registers and the APB register port.
`include "rtirq_consts.svh"
module rtirq_regs
  import rtirq_pkg::*;
(
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  input  wire rtirq_apb_req_type apb_i,
  output logic                  pready_o,
  output logic                  pslverr_o,
  output logic [31:0]           prdata_o,
  input  wire rtirq_events_type ev_i,
  input  wire logic             subsystem_fail_input_i,
  input  wire logic             lock_i,
  input  wire logic [5:0]       addr_pins_i,
  input  wire logic             terminal_active_i,
  input  wire logic             mode_code_stw_i,
  output logic                  high_priority_irq_out_o,
  output logic                  standard_irq_level_out_o,
  output logic                  standard_irq_pulse_out_o,
  output logic [5:0]            status_flags_o,
  output logic [15:0]           stw_tx_o,
  output logic                  stw_tx_valid_o,
  output logic                  terminal_halt_o,
  output logic                  self_test_busy_o,
  output logic                  prog_reset_o,
  output logic                  monitor_mode_o,
  output logic [7:0]            time_tag_o,
  output logic                  irq_o
);
  localparam int unsigned ST_CYC = `RTIRQ_SELFTEST_CYC;
  localparam int unsigned PR_CYC = `RTIRQ_PRST_CYC;

  // pin synchronisers
  logic [1:0]  ssf_s_q;
  logic [1:0]  lock_s_q;
  logic [11:0] apin_s_q;
  logic        ssf_prev_q;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ssf_s_q  <= 2'h0;
      lock_s_q <= 2'h0;
      apin_s_q <= 12'h000;
      ssf_prev_q <= 1'b0;
    end else begin
      ssf_s_q  <= {ssf_s_q[0], subsystem_fail_input_i};
      lock_s_q <= {lock_s_q[0], lock_i};
      apin_s_q <= {apin_s_q[5:0], addr_pins_i};
      ssf_prev_q <= ssf_s_q[1];
    end
  end
  wire       lock_w    = lock_s_q[1];
  wire [5:0] apin_w    = apin_s_q[11:6];
  wire       ssf_rise  = ssf_s_q[1] & ~ssf_prev_q;

  // apb decode, zero-wait slave
  wire        acc      = apb_i.psel & apb_i.penable;
  wire        wr       = acc & apb_i.pwrite;
  wire [4:0]  idx      = apb_i.paddr[6:2];
  wire [15:0] wd       = apb_i.pwdata[15:0];
  wire wr_hpen   = wr && idx == `RTIRQ_IDX_HP_EN;
  wire wr_hpst   = wr && idx == `RTIRQ_IDX_HP_STAT;
  wire wr_stden  = wr && idx == `RTIRQ_IDX_STD_EN;
  wire wr_taddr  = wr && idx == `RTIRQ_IDX_TADDR;
  wire wr_st     = wr && idx == `RTIRQ_IDX_SELFTEST;
  wire wr_prst   = wr && idx == `RTIRQ_IDX_PRST;
  wire wr_tt     = wr && idx == `RTIRQ_IDX_TTRST;
  wire wr_mon    = wr && idx == `RTIRQ_IDX_MONCTL;
  wire wr_stw    = wr && idx == `RTIRQ_IDX_STW;
  wire wr_iclr   = wr && idx == `RTIRQ_IDX_IRQ_CLR;
  wire wr_ien    = wr && idx == `RTIRQ_IDX_IRQ_EN;

  logic [15:0] hp_en_q, hp_st_q, std_en_q, taddr_q, stw_q;
  logic        busy_req_q, mon_q;
  logic [7:0]  tt_q;
  logic [3:0]  ist_q, ien_q;
  rtirq_state_type st_q;
  logic [13:0] cnt_q;

  // high-priority events
  wire st_done = (st_q == RTIRQ_SELFTEST) && cnt_q == 14'h0000;
  wire st_fail = st_done & ev_i.self_test_fail;
  wire std_ev  = |({ev_i.msg_error, ev_i.illegal_cmd, ev_i.illegal_bcast} &
                   {std_en_q[`RTIRQ_BIT_MSGERR], std_en_q[`RTIRQ_BIT_ILLCMD], std_en_q[`RTIRQ_BIT_ILLBC]}); // R9
  logic [15:0] hp_ev;
  always_comb begin
    hp_ev = 16'h0000;
    hp_ev[`RTIRQ_BIT_STD]    = std_ev;
    hp_ev[`RTIRQ_BIT_MSGERR] = ev_i.msg_error;
    hp_ev[`RTIRQ_BIT_STFAIL] = st_fail;
    hp_ev[`RTIRQ_BIT_STDONE] = st_done;
    hp_ev[`RTIRQ_BIT_SSFAIL] = ssf_rise; // R8
    hp_ev[`RTIRQ_BIT_DBCA]   = ev_i.dyn_bus_accept;
    hp_ev[`RTIRQ_BIT_OVR]    = ev_i.data_overrun;
  end
  // set wins over clear; a one on a clear bit does nothing
  wire [15:0] hp_set  = hp_ev & hp_en_q & `RTIRQ_HP_MASK; // R1 R5
  wire [15:0] hp_clr  = wr_hpst ? wd : 16'h0000;
  wire [15:0] hp_st_d = ((hp_st_q & ~hp_clr) | hp_set) & `RTIRQ_HP_MASK; // R6 R7

  // busy applied only while idle
  wire        busy_apply = ~terminal_active_i; // R12
  logic [15:0] taddr_d;
  always_comb begin
    taddr_d = taddr_q;
    if (wr_taddr) begin
      taddr_d[15:10] = wd[15:10]; // R11
      if (!lock_w)
        taddr_d[5:0] = wd[5:0]; // R10
    end
    if (lock_w)
      taddr_d[5:0] = apin_w; // R10
    taddr_d[6]  = ^apin_w[4:0] == apin_w[5];
    taddr_d[7]  = lock_w;
    taddr_d[8]  = 1'b0;
    taddr_d[`RTIRQ_TA_BUSYEN] = busy_apply ? busy_req_q : taddr_q[`RTIRQ_TA_BUSYEN]; // R12
    taddr_d[`RTIRQ_TA_BUSY]   = busy_apply ? busy_req_q : taddr_q[`RTIRQ_TA_BUSY]; // R12
  end

  // generic interrupt block over four events
  wire       prog_done = (st_q == RTIRQ_PRESET) && cnt_q == 14'h0000;
  wire [3:0] iev = {st_done, prog_done, hp_set[`RTIRQ_BIT_MSGERR], ssf_rise};

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hp_en_q  <= 16'h0000;
      hp_st_q  <= 16'h0000;
      std_en_q <= 16'h0000;
      taddr_q  <= 16'h0000;
      busy_req_q <= 1'b0;
      mon_q    <= 1'b0;
      stw_q    <= 16'h0000;
      ist_q    <= 4'h0;
      ien_q    <= 4'h0;
    end else begin
      if (wr_hpen)  hp_en_q  <= wd & (`RTIRQ_HP_MASK | 16'h0001);
      if (wr_stden) std_en_q <= wd & `RTIRQ_STD_MASK;
      if (wr_taddr) busy_req_q <= wd[`RTIRQ_TA_BUSYEN];
      if (wr_mon)   mon_q <= wd[`RTIRQ_MON_BIT]; // R16
      if (wr_stw)   stw_q <= wd; // R17
      if (wr_ien)   ien_q <= wd[3:0];
      hp_st_q <= hp_st_d;
      taddr_q <= taddr_d;
      ist_q   <= (ist_q & ~(wr_iclr ? wd[3:0] : 4'h0)) | iev;
    end
  end

  // command sequencer: self-test and programmed reset
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q  <= RTIRQ_IDLE;
      cnt_q <= 14'h0000;
    end else begin
      case (st_q)
        RTIRQ_IDLE: begin
          if (wr_prst) begin
            st_q  <= RTIRQ_PRESET; // R14
            cnt_q <= 14'(PR_CYC - 1);
          end else if (wr_st) begin
            st_q  <= RTIRQ_SELFTEST; // R13
            cnt_q <= 14'(ST_CYC - 1);
          end
        end
        RTIRQ_SELFTEST, RTIRQ_PRESET: begin
          if (wr_prst && st_q == RTIRQ_SELFTEST) begin
            st_q  <= RTIRQ_PRESET;
            cnt_q <= 14'(PR_CYC - 1);
          end else if (cnt_q == 14'h0000)
            st_q <= RTIRQ_IDLE;
          else
            cnt_q <= cnt_q - 14'h0001;
        end
        default: st_q <= RTIRQ_IDLE;
      endcase
    end
  end

  // halt on enabled message error until status bit 1 clears
  wire halt_d = hp_st_d[`RTIRQ_BIT_MSGERR] & hp_en_q[`RTIRQ_BIT_MSGERR]; // R4

  // read mux; command registers read zero
  logic [15:0] rd;
  always_comb begin
    case (idx)
      `RTIRQ_IDX_HP_EN:    rd = hp_en_q;
      `RTIRQ_IDX_HP_STAT:  rd = hp_st_q;
      `RTIRQ_IDX_STD_EN:   rd = std_en_q;
      `RTIRQ_IDX_TADDR:    rd = taddr_q;
      `RTIRQ_IDX_MONCTL:   rd = {mon_q, 15'h0000};
      `RTIRQ_IDX_STW:      rd = stw_q;
      `RTIRQ_IDX_IRQ_STAT: rd = {12'h000, ist_q};
      `RTIRQ_IDX_IRQ_EN:   rd = {12'h000, ien_q};
      `RTIRQ_IDX_TTAG:     rd = {8'h00, tt_q};
      default:             rd = 16'h0000; // R18
    endcase
  end
  wire known = idx inside {`RTIRQ_IDX_HP_EN, `RTIRQ_IDX_HP_STAT, `RTIRQ_IDX_STD_EN,
    `RTIRQ_IDX_TADDR, `RTIRQ_IDX_SELFTEST, `RTIRQ_IDX_PRST, `RTIRQ_IDX_TTRST,
    `RTIRQ_IDX_MONCTL, `RTIRQ_IDX_STW, `RTIRQ_IDX_IRQ_STAT, `RTIRQ_IDX_IRQ_CLR,
    `RTIRQ_IDX_IRQ_EN, `RTIRQ_IDX_TTAG};

  // registered outputs
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      high_priority_irq_out_o  <= 1'b0;
      standard_irq_level_out_o <= 1'b0;
      standard_irq_pulse_out_o <= 1'b0;
      status_flags_o   <= 6'h00;
      stw_tx_o         <= 16'h0000;
      stw_tx_valid_o   <= 1'b0;
      terminal_halt_o  <= 1'b0;
      self_test_busy_o <= 1'b0;
      prog_reset_o     <= 1'b0;
      monitor_mode_o   <= 1'b0;
      tt_q   <= 8'h00;
      irq_o  <= 1'b0;
    end else begin
      pready_o  <= apb_i.psel & ~apb_i.penable;
      pslverr_o <= apb_i.psel & ~apb_i.penable & ~known;
      prdata_o  <= {16'h0000, rd};
      high_priority_irq_out_o  <= |(hp_st_d & ~16'h0001); // R5 R6
      standard_irq_pulse_out_o <= std_ev; // R2
      standard_irq_level_out_o <= hp_st_d[`RTIRQ_BIT_STD]; // R3
      status_flags_o   <= taddr_d[15:10]; // R11
      stw_tx_o         <= stw_q;
      stw_tx_valid_o   <= mode_code_stw_i; // R17
      terminal_halt_o  <= halt_d | (st_q == RTIRQ_PRESET) | wr_prst; // R4 R14
      self_test_busy_o <= (st_q == RTIRQ_SELFTEST) ? ~st_done : wr_st;
      prog_reset_o     <= (st_q == RTIRQ_PRESET) ? ~prog_done : wr_prst;
      monitor_mode_o   <= wr_mon ? wd[`RTIRQ_MON_BIT] : mon_q;
      tt_q   <= wr_tt ? 8'h00 : tt_q + 8'h01; // R15
      irq_o  <= |(((ist_q & ~(wr_iclr ? wd[3:0] : 4'h0)) | iev) & ien_q);
    end
  end
  assign time_tag_o = tt_q;

  hp_set_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (ev_i.data_overrun && hp_en_q[`RTIRQ_BIT_OVR]) |=> hp_st_q[`RTIRQ_BIT_OVR] && high_priority_irq_out_o)
    else $error("overrun event lost"); // R5
  hp_gate_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !hp_en_q[`RTIRQ_BIT_OVR] && !hp_st_q[`RTIRQ_BIT_OVR] |=> !hp_st_q[`RTIRQ_BIT_OVR])
    else $error("disabled event set status"); // R1
  w1c_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (wr_hpst && wd[`RTIRQ_BIT_DBCA] && !hp_set[`RTIRQ_BIT_DBCA]) |=> !hp_st_q[`RTIRQ_BIT_DBCA])
    else $error("status bit not cleared"); // R6
  w1c_noset_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (!hp_st_q[`RTIRQ_BIT_DBCA] && !hp_set[`RTIRQ_BIT_DBCA]) |=> !hp_st_q[`RTIRQ_BIT_DBCA])
    else $error("status bit set without event"); // R7
  std_pulse_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (std_ev && !hp_en_q[0] && !hp_st_q[0]) |=> standard_irq_pulse_out_o && !standard_irq_level_out_o)
    else $error("standard pulse only broken"); // R2
  std_level_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (std_ev && hp_en_q[0]) |=> standard_irq_pulse_out_o && standard_irq_level_out_o)
    else $error("standard level missing"); // R3
  lock_mirror_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    lock_w |=> taddr_q[5:0] == $past(apin_w))
    else $error("address not mirrored"); // R10
  tt_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    wr_tt |=> time_tag_o == 8'h00)
    else $error("time tag not cleared"); // R15
  prst_len_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (wr_prst && st_q == RTIRQ_IDLE) |=> prog_reset_o [*8])
    else $error("programmed reset too short"); // R14
  halt_msg_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (ev_i.msg_error && hp_en_q[`RTIRQ_BIT_MSGERR]) |=> terminal_halt_o)
    else $error("no halt on message error"); // R4
  c_selftest: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) st_done);
  c_hpirq: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) $rose(high_priority_irq_out_o));
  c_stdlvl: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) $rose(standard_irq_level_out_o));
endmodule

//--- bench/rtirq_bus_model.sv
// bus-side event source issuing one-cycle event pulses
module rtirq_bus_model
  import rtirq_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       fire_i,
  input  wire logic [2:0] sel_i,
  output rtirq_events_type ev_o
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ev_o <= '0;
    end else begin
      ev_o <= fire_i ? rtirq_events_type'(7'h40 >> sel_i) : '0;
    end
  end
endmodule

//--- bench/testbench.sv
// self-checking bench for the terminal register bank
`include "rtirq_consts.svh"
module testbench
  import rtirq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  rtirq_apb_req_type req = '0;
  logic              fire = 1'b0;
  logic [2:0]        sel = 3'h0;
  logic              ssf = 1'b0;
  logic              lock = 1'b0;
  logic [5:0]        pins = 6'h00;
  logic              act = 1'b0;
  logic              stw_req = 1'b0;
  rtirq_events_type  ev;
  logic              pready, pslverr, hp, lvl, pls, stwv, halt, stb, prst, mon, irq;
  logic [31:0]       prdata;
  logic [5:0]        flags;
  logic [15:0]       stw;
  logic [7:0]        ttag;
  logic [31:0]       exp_q[$];
  logic [15:0]       stw_exp = 16'h0000;
  int                errors = 0;
  int                checks = 0;
  int                pulses = 0;
  int                stw_n = 0;
  int                n;
  always #4 clk = ~clk;
  rtirq_regs dut (.core_clk_i(clk), .rst_n_i(rst_n), .apb_i(req), .pready_o(pready), .pslverr_o(pslverr),
    .prdata_o(prdata), .ev_i(ev), .subsystem_fail_input_i(ssf), .lock_i(lock), .addr_pins_i(pins),
    .terminal_active_i(act), .mode_code_stw_i(stw_req), .high_priority_irq_out_o(hp),
    .standard_irq_level_out_o(lvl), .standard_irq_pulse_out_o(pls), .status_flags_o(flags),
    .stw_tx_o(stw), .stw_tx_valid_o(stwv), .terminal_halt_o(halt), .self_test_busy_o(stb),
    .prog_reset_o(prst), .monitor_mode_o(mon), .time_tag_o(ttag), .irq_o(irq));
  rtirq_bus_model bus (.clk_i(clk), .rst_n_i(rst_n), .fire_i(fire), .sel_i(sel), .ev_o(ev));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input logic w, input logic [4:0] idx, input logic [15:0] d, input logic [15:0] m);
    int k;
    k = 0;
    @(posedge clk);
    if (!w) exp_q.push_back({d, m});
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {idx, 2'b00}, pwdata: {16'h0000, d}};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && k++ < 50);
    if (k >= 50) errors++;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] idx, input logic [15:0] d);
    xfer(1'b1, idx, d, 16'h0000);
  endtask
  task automatic rd(input logic [4:0] idx, input logic [15:0] d, input logic [15:0] m);
    xfer(1'b0, idx, d, m);
  endtask
  task automatic st();
    repeat (4) @(posedge clk);
  endtask
  task automatic pulse_ev(input logic [2:0] s);
    sel <= s;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    st();
  endtask
  task automatic span(input logic [4:0] idx, input int exp);
    wr(idx, 16'h5A5A);
    @(posedge clk);
    n = 0;
    while (((idx == `RTIRQ_IDX_PRST) ? prst : stb) === 1'b1 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    check("busy_span", n, exp);
  endtask
  task automatic endt(input string s);
    $display("test %s finished", s);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // read scoreboard: oldest note against each completed read
  always @(posedge clk) begin
    if (req.psel && req.penable && !req.pwrite && pready === 1'b1) begin
      check("read_data", prdata & {16'hFFFF, exp_q[0][15:0]}, {16'h0000, exp_q[0][31:16] & exp_q[0][15:0]});
      exp_q.delete(0);
    end
    if (req.psel && req.penable && pready === 1'b1)
      check("slave_error", pslverr, 32'(req.paddr[6:2] == 5'h1F));
    if (pls === 1'b1) pulses++;
    if (stwv === 1'b1) begin
      stw_n++;
      check("result_word", 32'(stw), 32'(stw_exp));
    end
  end
  initial begin
    #(8 * 30000);
    errors++;
    test_done();
  end
  initial begin
    logic [15:0] r;
    logic [15:0] tab [2];
    tab = '{16'h0040, 16'h0100};
    void'($urandom(91621));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    r = 16'($urandom);
    wr(`RTIRQ_IDX_HP_EN, r);
    rd(`RTIRQ_IDX_HP_EN, r, `RTIRQ_HP_MASK);
    wr(`RTIRQ_IDX_STD_EN, ~r);
    rd(`RTIRQ_IDX_STD_EN, ~r, `RTIRQ_STD_MASK);
    for (int i = 11; i <= 13; i++) rd(5'(i), 16'h0000, 16'hFFFF);
    rd(5'h1F, 16'h0000, 16'hFFFF);
    check("selftest_busy", stb, 1'b0);
    wr(`RTIRQ_IDX_HP_STAT, 16'h017B);
    rd(`RTIRQ_IDX_HP_STAT, 16'h0000, 16'h017B);
    wr(`RTIRQ_IDX_HP_EN, 16'h0000);
    pulse_ev(3'd3);
    check("hp_out", hp, 1'b0);
    wr(`RTIRQ_IDX_HP_STAT, 16'h017B);
    for (int i = 0; i < 2; i++) begin
      wr(`RTIRQ_IDX_HP_EN, tab[i]);
      pulse_ev(3'(i + 2));
      check("hp_out", hp, 1'b1);
      rd(`RTIRQ_IDX_HP_STAT, tab[i], 16'h017B);
      wr(`RTIRQ_IDX_HP_STAT, tab[i]);
      st();
      check("hp_out", hp, 1'b0);
    end
    wr(`RTIRQ_IDX_HP_EN, 16'h0002);
    wr(`RTIRQ_IDX_IRQ_EN, 16'h0002);
    pulse_ev(3'd0);
    check("halt", halt, 1'b1);
    check("irq", irq, 1'b1);
    rd(`RTIRQ_IDX_IRQ_STAT, 16'h0002, 16'h0002);
    wr(`RTIRQ_IDX_IRQ_EN, 16'h0000);
    st();
    check("irq", irq, 1'b0);
    wr(`RTIRQ_IDX_IRQ_CLR, 16'h0002);
    rd(`RTIRQ_IDX_IRQ_STAT, 16'h0000, 16'h0002);
    wr(`RTIRQ_IDX_HP_STAT, 16'h0002);
    st();
    check("halt", halt, 1'b0);
    check("hp_out", hp, 1'b0);
    endt("high_priority");
    wr(`RTIRQ_IDX_HP_EN, 16'h0000);
    wr(`RTIRQ_IDX_STD_EN, 16'h0010);
    pulses = 0;
    pulse_ev(3'd5);
    check("pulses", pulses, 0);
    pulse_ev(3'd4);
    check("pulses", pulses, 1);
    check("level", lvl, 1'b0);
    wr(`RTIRQ_IDX_HP_EN, 16'h0001);
    pulse_ev(3'd4);
    check("pulses", pulses, 2);
    check("level", lvl, 1'b1);
    wr(`RTIRQ_IDX_HP_STAT, 16'h0001);
    st();
    check("level", lvl, 1'b0);
    wr(`RTIRQ_IDX_HP_EN, 16'h0020);
    ssf <= 1'b1;
    repeat (2) st();
    check("hp_out", hp, 1'b1);
    rd(`RTIRQ_IDX_HP_STAT, 16'h0020, 16'h0020);
    ssf <= 1'b0;
    wr(`RTIRQ_IDX_HP_STAT, 16'h0020);
    endt("standard");
    r = 16'($urandom);
    pins <= r[5:0];
    lock <= 1'b1;
    st();
    wr(`RTIRQ_IDX_TADDR, ~r);
    rd(`RTIRQ_IDX_TADDR, r, `RTIRQ_TA_ADDR_MASK);
    lock <= 1'b0;
    act <= 1'b1;
    st();
    wr(`RTIRQ_IDX_TADDR, {r[15:10], 4'h8, ~r[5:0]});
    rd(`RTIRQ_IDX_TADDR, {1'b0, ~r[9], 4'h0, ~r[9], 3'h0, ~r[5:0]}, 16'h423F);
    act <= 1'b0;
    st();
    rd(`RTIRQ_IDX_TADDR, {r[15], 1'b1, r[13:10], 4'h8, ~r[5:0]}, 16'hFE3F);
    check("flags", flags, {r[15], 1'b1, r[13:10]});
    repeat (20) @(posedge clk);
    wr(`RTIRQ_IDX_TTRST, r);
    @(posedge clk);
    check("time_tag", ttag, 8'h00);
    wr(`RTIRQ_IDX_MONCTL, 16'h8000);
    rd(`RTIRQ_IDX_MONCTL, 16'h8000, 16'h8000);
    check("monitor", mon, 1'b1);
    wr(`RTIRQ_IDX_MONCTL, 16'h0000);
    rd(`RTIRQ_IDX_MONCTL, 16'h0000, 16'h8000);
    check("monitor", mon, 1'b0);
    stw_exp = r;
    wr(`RTIRQ_IDX_STW, r);
    stw_req <= 1'b1;
    @(posedge clk);
    stw_req <= 1'b0;
    st();
    check("result_pulses", stw_n, 1);
    endt("address_and_words");
    wr(`RTIRQ_IDX_IRQ_CLR, 16'h000F);
    span(`RTIRQ_IDX_PRST, `RTIRQ_PRST_CYC);
    wr(`RTIRQ_IDX_HP_EN, 16'h0018);
    span(`RTIRQ_IDX_SELFTEST, `RTIRQ_SELFTEST_CYC);
    rd(`RTIRQ_IDX_HP_STAT, 16'h0010, 16'h0018);
    rd(`RTIRQ_IDX_IRQ_STAT, 16'h000C, 16'h000C);
    endt("commands");
    test_done();
  end
endmodule
